// file: eirq_pkg.sv
`default_nettype none
package eirq_pkg;
    // ==================================================
    // Register map (word offsets on the Avalon bus)
    localparam logic [3:0] ADDR_MCU_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_SENSE      = 4'h4;
    localparam logic [3:0] ADDR_ENABLE     = 4'h8;
    localparam logic [3:0] ADDR_FLAG       = 4'hc;
    // ==================================================
    // Field positions
    localparam int UNLOCK_BIT    = 0;
    localparam int SELECT_BIT    = 1;
    localparam int NUM_PINS      = 4;
    // ==================================================
    // Reset values
    localparam logic [7:0] SENSE_RESET  = 8'h00;
    localparam logic [3:0] ENABLE_RESET = 4'h0;
    // ==================================================
    // Sense encodings
    localparam logic [1:0] SENSE_LOW     = 2'h0;
    localparam logic [1:0] SENSE_CHANGE  = 2'h1;
    localparam logic [1:0] SENSE_FALL    = 2'h2;
    localparam logic [1:0] SENSE_RISE    = 2'h3;
    // ==================================================
    // Timing
    localparam int UNLOCK_CYCLES = 4;
    localparam logic [2:0] UNLOCK_COUNT = 3'(UNLOCK_CYCLES);
    // ==================================================
    // Vector addresses (word addresses)
    localparam logic [15:0] APP_VECTOR_BASE  = 16'h0004;
    localparam logic [15:0] BOOT_RESET_ADDR  = 16'h4c00;
    localparam logic [15:0] BOOT_VEC_FIRST   = 16'h4c02;
    localparam logic [15:0] BOOT_VEC_LAST    = 16'h4c2c;
    localparam logic [15:0] VECTOR_STRIDE    = 16'h0002;
endpackage : eirq_pkg
`default_nettype wire

// file: ext_irq_vector_select.sv
// Function
// R1: Select bit picks flash or boot vectors
// R2: Software sets unlock, then writes select within four
// R3: Unlock clears after four cycles or select write
// R4: Interrupts blocked during the unlock window
// R5: Blocking leaves global enable untouched
// R6: Lock bits block interrupts in other section
// R7: Pins trigger even when driven as outputs
// R8: Sense field: low, change, falling, rising
// R9: Low level requests while pin is low
// R10: Edges captured without the CPU clock; here edges are only seen through flops clocked by CLOCK_I
// R11: Level wake sampled twice on slow clock
// R12: Pulses above minimum width are caught
// R13: Source holds level until instruction ends
// R14: Pin enable and global enable gate request
// R15: Edge sets flag; vector or write-one clears
// R16: Enable, global and flag request the vector
// R17: Flag reads zero under level sensing
// R18: Sleep buffer disable may set flags
// R19: Software disables before changing sense
// R20: Upper four bits of mask and flag read zero
// R21: Boot vectors from 0x4c02 up to 0x4c2c
// R22: Flash vectors 0x0004 to 0x000a for pins
// R23: Edge events pass two-stage synchroniser
//
// Register access over Avalon-MM and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
module ext_irq_vector_select (
    input  wire logic        CLOCK_I,
    input  wire logic        RST_B_I,
    input  wire logic [3:0]  AVS_ADDRESS_I,
    input  wire logic        AVS_READ_I,
    input  wire logic        AVS_WRITE_I,
    input  wire logic [31:0] AVS_WRITEDATA_I,
    input  wire logic [3:0]  AVS_BYTEENABLE_I,
    output logic      [31:0] AVS_READDATA_O,
    output logic             AVS_WAITREQUEST_O,
    input  wire logic [3:0]  EXT_IRQ_PINS_I,
    input  wire logic        GLOBAL_IRQ_ENABLE_I,
    input  wire logic        EXEC_IN_BOOT_I,
    input  wire logic        APP_PROTECT_LOCK_BIT_I,
    input  wire logic        BOOT_PROTECT_LOCK_BIT_I,
    input  wire logic        INSTR_DONE_I,
    input  wire logic        IRQ_ACK_I,
    input  wire logic [1:0]  IRQ_ACK_PIN_I,
    output logic             IRQ_REQ_O,
    output logic      [1:0]  IRQ_PIN_O,
    output logic      [15:0] IRQ_VECTOR_O,
    output logic             VECTOR_BASE_SELECT_O,
    output logic             IRQ_BLOCKED_O
);
    // ==================================================
    // Bus decode
    logic       wr_ok;
    logic       wr_ctrl;
    logic       wr_sense;
    logic       wr_enable;
    logic       wr_flag;
    logic       rd_pending;

    // A read answers one cycle later; a write is taken at once
    assign AVS_WAITREQUEST_O = AVS_READ_I & ~rd_pending;
    assign wr_ok     = AVS_WRITE_I & AVS_BYTEENABLE_I[0];
    assign wr_ctrl   = wr_ok && AVS_ADDRESS_I == eirq_pkg::ADDR_MCU_CTRL;
    assign wr_sense  = wr_ok && AVS_ADDRESS_I == eirq_pkg::ADDR_SENSE;
    assign wr_enable = wr_ok && AVS_ADDRESS_I == eirq_pkg::ADDR_ENABLE;
    assign wr_flag   = wr_ok && AVS_ADDRESS_I == eirq_pkg::ADDR_FLAG;

    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rd_pending <= 1'b0;
        end else begin
            rd_pending <= AVS_READ_I & ~rd_pending;
        end
    end

    // ==================================================
    // Control registers
    logic [7:0] sense;
    logic [3:0] enable;
    logic       select;
    logic       unlock;
    logic [2:0] unlock_cnt;
    logic       post_block;

    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            sense  <= eirq_pkg::SENSE_RESET;
            enable <= eirq_pkg::ENABLE_RESET;
        end else begin
            if (wr_sense) begin
                sense <= AVS_WRITEDATA_I[7:0];
            end
            if (wr_enable) begin
                enable <= AVS_WRITEDATA_I[3:0];
            end
        end
    end

    // Select changes only while unlocked and unlock written zero
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            select     <= 1'b0;
            unlock     <= 1'b0;
            unlock_cnt <= 3'h0;
            post_block <= 1'b0;
        end else begin
            if (wr_ctrl && AVS_WRITEDATA_I[eirq_pkg::UNLOCK_BIT]) begin
                unlock     <= 1'b1;
                unlock_cnt <= eirq_pkg::UNLOCK_COUNT;
            end else if (wr_ctrl && unlock) begin
                select     <= AVS_WRITEDATA_I[eirq_pkg::SELECT_BIT]; // R1
                unlock     <= 1'b0; // R3
                unlock_cnt <= 3'h0;
                post_block <= 1'b1; // R4
            end else if (unlock) begin
                unlock_cnt <= unlock_cnt - 3'h1;
                if (unlock_cnt == 3'h1) begin
                    unlock <= 1'b0; // R3
                end
            end
            if (post_block && INSTR_DONE_I && !(wr_ctrl && unlock)) begin
                post_block <= 1'b0; // R4
            end
        end
    end

    // Global enable is read, never written here
    logic lock_block;
    assign lock_block = (select & APP_PROTECT_LOCK_BIT_I & ~EXEC_IN_BOOT_I)
                      | (~select & BOOT_PROTECT_LOCK_BIT_I
                         & EXEC_IN_BOOT_I); // R6
    assign IRQ_BLOCKED_O = unlock | post_block | lock_block; // R4 R5
    assign VECTOR_BASE_SELECT_O = select;

    // ==================================================
    // Pin capture
    // The pin is sampled by three flops; edges are judged on the
    // two later stages, s2 and s3, so a metastable first stage is never read.
    // Pulses shorter than one clock may be missed, which the minimum
    // width allows.
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;

    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            s1 <= 4'hf;
            s2 <= 4'hf;
            s3 <= 4'hf;
        end else begin
            s1 <= EXT_IRQ_PINS_I; // R7 R10 R12 R23
            s2 <= s1;
            s3 <= s2;
        end
    end

    // ==================================================
    // Flags
    logic [3:0] flag;
    logic [3:0] edge_hit;
    logic [3:0] level_hit;
    logic [3:0] ack_clr;
    logic [3:0] sw_clr;

    always_comb begin
        for (int n = 0; n < eirq_pkg::NUM_PINS; n++) begin
            case (sense[2*n +: 2]) // R8
                eirq_pkg::SENSE_LOW:    edge_hit[n] = 1'b0;
                eirq_pkg::SENSE_CHANGE: edge_hit[n] = s2[n] ^ s3[n];
                eirq_pkg::SENSE_FALL:   edge_hit[n] = ~s2[n] & s3[n];
                eirq_pkg::SENSE_RISE:   edge_hit[n] = s2[n] & ~s3[n];
                default:                edge_hit[n] = 1'b0;
            endcase
            level_hit[n] = (sense[2*n +: 2] == eirq_pkg::SENSE_LOW)
                         & ~s2[n] & ~s3[n]; // R9 R11
            ack_clr[n] = IRQ_ACK_I && IRQ_ACK_PIN_I == 2'(n);
        end
    end
    assign sw_clr = wr_flag ? AVS_WRITEDATA_I[3:0] : 4'h0;

    // Set wins over a clear arriving in the same cycle
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            flag <= 4'h0;
        end else begin
            flag <= edge_hit | (flag & ~sw_clr & ~ack_clr); // R15 R18
        end
    end

    logic [3:0] flag_vis;
    always_comb begin
        for (int n = 0; n < eirq_pkg::NUM_PINS; n++) begin
            flag_vis[n] = flag[n]
                & (sense[2*n +: 2] != eirq_pkg::SENSE_LOW); // R17
        end
    end

    // ==================================================
    // Request and vector
    logic [3:0] pend;
    logic [1:0] pick;
    assign pend = (flag_vis | level_hit) & enable; // R14 R16

    always_comb begin
        pick = 2'h0;
        for (int n = eirq_pkg::NUM_PINS - 1; n >= 0; n--) begin
            if (pend[n]) begin
                pick = 2'(n);
            end
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            IRQ_REQ_O    <= 1'b0;
            IRQ_PIN_O    <= 2'h0;
            IRQ_VECTOR_O <= eirq_pkg::APP_VECTOR_BASE;
        end else begin
            IRQ_REQ_O    <= (|pend) & GLOBAL_IRQ_ENABLE_I
                          & ~IRQ_BLOCKED_O & ~IRQ_ACK_I; // R16 R4 R6
            IRQ_PIN_O    <= pick;
            IRQ_VECTOR_O <= (select ? eirq_pkg::BOOT_VEC_FIRST
                                    : eirq_pkg::VECTOR_STRIDE)
                          + eirq_pkg::VECTOR_STRIDE
                          + 16'({pick, 1'b0}); // R1 R21 R22
        end
    end

    // ==================================================
    // Read data
    always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            AVS_READDATA_O <= 32'h0;
        end else if (AVS_READ_I && !rd_pending) begin
            case (AVS_ADDRESS_I)
                eirq_pkg::ADDR_MCU_CTRL:
                    AVS_READDATA_O <= {30'h0, select, unlock};
                eirq_pkg::ADDR_SENSE:
                    AVS_READDATA_O <= {24'h0, sense};
                eirq_pkg::ADDR_ENABLE:
                    AVS_READDATA_O <= {28'h0, enable}; // R20
                eirq_pkg::ADDR_FLAG:
                    AVS_READDATA_O <= {28'h0, flag_vis}; // R20
                default:
                    AVS_READDATA_O <= 32'h0;
            endcase
        end
    end

    // ==================================================
    // Checks
    // Registered outputs are judged one edge after their cause, so most
    // checks use the next-cycle implication.
    AST_UNLOCK_EXPIRES: assert property (@(posedge CLOCK_I) // R3
        disable iff (!RST_B_I)
        (wr_ctrl && AVS_WRITEDATA_I[eirq_pkg::UNLOCK_BIT])
        ##1 (!wr_ctrl)[*4] |=> !unlock)
        else $error("unlock did not expire");
    AST_SELECT_CLEARS_UNLOCK: assert property (@(posedge CLOCK_I) // R3
        disable iff (!RST_B_I)
        (wr_ctrl && unlock && !AVS_WRITEDATA_I[0]) |=> !unlock)
        else $error("unlock kept after select write");
    AST_BLOCK_DURING_UNLOCK: assert property (@(posedge CLOCK_I) // R4
        disable iff (!RST_B_I)
        unlock |=> !IRQ_REQ_O)
        else $error("request while unlocked");
    AST_SELECT_LOCKED: assert property (@(posedge CLOCK_I) // R1
        disable iff (!RST_B_I)
        (!unlock && !$past(unlock)) |=> $stable(select))
        else $error("select changed without unlock");
    AST_LEVEL_FLAG_ZERO: assert property (@(posedge CLOCK_I) // R17
        disable iff (!RST_B_I)
        (sense[1:0] == eirq_pkg::SENSE_LOW) |-> !flag_vis[0])
        else $error("flag visible in level mode");
    AST_RISE_SETS_FLAG: assert property (@(posedge CLOCK_I) // R15
        disable iff (!RST_B_I)
        (sense[7:6] == eirq_pkg::SENSE_RISE && s2[3] && !s3[3])
        |=> flag[3])
        else $error("rising edge lost");
    AST_RESERVED_ZERO: assert property (@(posedge CLOCK_I) // R20
        disable iff (!RST_B_I)
        $past(AVS_READ_I && !rd_pending
              && AVS_ADDRESS_I == eirq_pkg::ADDR_FLAG)
        |-> AVS_READDATA_O[7:4] == 4'h0)
        else $error("reserved flag bits set");
    AST_REQ_NEEDS_GLOBAL: assert property (@(posedge CLOCK_I) // R14 R16
        disable iff (!RST_B_I)
        IRQ_REQ_O |-> $past(GLOBAL_IRQ_ENABLE_I && |pend))
        else $error("request without enable");
    AST_BOOT_VECTOR: assert property (@(posedge CLOCK_I) // R21
        disable iff (!RST_B_I)
        $past(select) && $past(pick) == 2'h0
        |-> IRQ_VECTOR_O == 16'h4c04)
        else $error("boot vector wrong");
    // ==================================================
    // Checks on sequencing, gating and vectors
    AST_UNLOCK_SETS: assert property (@(posedge CLOCK_I) // R3
        disable iff (!RST_B_I)
        (wr_ctrl && AVS_WRITEDATA_I[eirq_pkg::UNLOCK_BIT]) |=> unlock)
        else $error("unlock not set");
    AST_UNLOCK_COUNTS: assert property (@(posedge CLOCK_I) // R3
        disable iff (!RST_B_I)
        (unlock && !wr_ctrl && unlock_cnt != 3'h1) |=> unlock)
        else $error("unlock ended early");
    AST_SELECT_WRITE: assert property (@(posedge CLOCK_I) // R1
        disable iff (!RST_B_I)
        (wr_ctrl && unlock && !AVS_WRITEDATA_I[eirq_pkg::UNLOCK_BIT])
        |=> select == $past(AVS_WRITEDATA_I[eirq_pkg::SELECT_BIT]))
        else $error("select write not taken");
    AST_POST_BLOCK_HOLDS: assert property (@(posedge CLOCK_I) // R4
        disable iff (!RST_B_I)
        (wr_ctrl && unlock && !AVS_WRITEDATA_I[0]) |=> IRQ_BLOCKED_O)
        else $error("no block after select write");
    AST_POST_BLOCK_ENDS: assert property (@(posedge CLOCK_I) // R4
        disable iff (!RST_B_I)
        (post_block && INSTR_DONE_I && !wr_ctrl) |=> !post_block)
        else $error("block outlived instruction");
    AST_BLOCKED_NO_REQ: assert property (@(posedge CLOCK_I) // R4
        disable iff (!RST_B_I)
        IRQ_BLOCKED_O |=> !IRQ_REQ_O)
        else $error("request while blocked");
    AST_LOCK_APP: assert property (@(posedge CLOCK_I) // R6
        disable iff (!RST_B_I)
        (select && APP_PROTECT_LOCK_BIT_I && !EXEC_IN_BOOT_I) |-> IRQ_BLOCKED_O)
        else $error("app lock not blocking");
    AST_LOCK_BOOT: assert property (@(posedge CLOCK_I) // R6
        disable iff (!RST_B_I)
        (!select && BOOT_PROTECT_LOCK_BIT_I && EXEC_IN_BOOT_I) |-> IRQ_BLOCKED_O)
        else $error("boot lock not blocking");
    AST_LEVEL_REQUEST: assert property (@(posedge CLOCK_I) // R9
        disable iff (!RST_B_I)
        (level_hit[0] && enable[0] && GLOBAL_IRQ_ENABLE_I
         && !IRQ_BLOCKED_O && !IRQ_ACK_I) |=> IRQ_REQ_O)
        else $error("low level not requesting");
    AST_CHANGE_SETS_FLAG: assert property (@(posedge CLOCK_I) // R8 R15
        disable iff (!RST_B_I)
        (sense[3:2] == eirq_pkg::SENSE_CHANGE && s2[1] != s3[1])
        |=> flag[1])
        else $error("change lost");
    AST_FALL_SETS_FLAG: assert property (@(posedge CLOCK_I) // R8 R15
        disable iff (!RST_B_I)
        (sense[5:4] == eirq_pkg::SENSE_FALL && !s2[2] && s3[2])
        |=> flag[2])
        else $error("falling edge lost");
    AST_SW_CLEAR: assert property (@(posedge CLOCK_I) // R15
        disable iff (!RST_B_I)
        (wr_flag && AVS_WRITEDATA_I[2] && !edge_hit[2])
        |=> !flag[2])
        else $error("write one did not clear flag");
    AST_ACK_CLEAR: assert property (@(posedge CLOCK_I) // R15
        disable iff (!RST_B_I)
        (ack_clr[1] && !edge_hit[1]) |=> !flag[1])
        else $error("vector did not clear flag");
    AST_ACK_DROPS_REQ: assert property (@(posedge CLOCK_I) // R16
        disable iff (!RST_B_I)
        IRQ_ACK_I |=> !IRQ_REQ_O)
        else $error("request kept after acknowledge");
    AST_APP_VECTOR: assert property (@(posedge CLOCK_I) // R22
        disable iff (!RST_B_I)
        (!$past(select) && $past(pick) == 2'h3)
        |-> IRQ_VECTOR_O == 16'h000a)
        else $error("flash vector wrong");
    AST_BOOT_RANGE: assert property (@(posedge CLOCK_I) // R21
        disable iff (!RST_B_I)
        $past(select) |-> (IRQ_VECTOR_O >= eirq_pkg::BOOT_VEC_FIRST
                           && IRQ_VECTOR_O <= eirq_pkg::BOOT_VEC_LAST))
        else $error("boot vector out of table");
    AST_RESERVED_MASK: assert property (@(posedge CLOCK_I) // R20
        disable iff (!RST_B_I)
        $past(AVS_READ_I && !rd_pending
              && AVS_ADDRESS_I == eirq_pkg::ADDR_ENABLE)
        |-> AVS_READDATA_O[31:4] == 28'h0)
        else $error("reserved mask bits set");
    AST_NO_GLOBAL_NO_REQ: assert property (@(posedge CLOCK_I) // R14
        disable iff (!RST_B_I)
        !GLOBAL_IRQ_ENABLE_I |=> !IRQ_REQ_O)
        else $error("request with global enable off");
endmodule : ext_irq_vector_select
`default_nettype wire

// file: ext_pin_source.sv
`timescale 1ns/100ps
`default_nettype none
module ext_pin_source (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic [3:0] level_i,
    input  wire logic       slow_i,
    output logic      [3:0] pins_o
);
    // ==========
    // Source drive
    logic [1:0] dly;
    // A level is held until told otherwise, far past one instruction
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pins_o <= 4'hf;
            dly    <= 2'h0;
        end else if (level_i == pins_o) begin
            dly <= 2'h0;
        end else if (dly == (slow_i ? 2'h3 : 2'h0)) begin
            pins_o <= level_i;
        end else begin
            dly <= dly + 2'h1;
        end
    end
endmodule : ext_pin_source
`default_nettype wire

// file: tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    // ==========
    // Signals
    logic        clk, rst_b, rd_en, wr_en, gie, boot, app_lk, boot_lk;
    logic        done, ack, slow, req, sel, blk, wreq;
    logic [3:0]  adr, be, lvl, pins;
    logic [1:0]  ackp, rpin;
    logic [15:0] vec;
    logic [31:0] wdat, rdat, seed;
    logic [31:0] q[$];
    int          error_cnt, checked, cyc;

    ext_irq_vector_select ext_irq_vector_select_inst (
        .CLOCK_I(clk), .RST_B_I(rst_b), .AVS_ADDRESS_I(adr),
        .AVS_READ_I(rd_en), .AVS_WRITE_I(wr_en),
        .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(be),
        .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq),
        .EXT_IRQ_PINS_I(pins), .GLOBAL_IRQ_ENABLE_I(gie),
        .EXEC_IN_BOOT_I(boot), .APP_PROTECT_LOCK_BIT_I(app_lk),
        .BOOT_PROTECT_LOCK_BIT_I(boot_lk), .INSTR_DONE_I(done),
        .IRQ_ACK_I(ack), .IRQ_ACK_PIN_I(ackp), .IRQ_REQ_O(req),
        .IRQ_PIN_O(rpin), .IRQ_VECTOR_O(vec),
        .VECTOR_BASE_SELECT_O(sel), .IRQ_BLOCKED_O(blk));

    ext_pin_source ext_pin_source_inst (.clk_i(clk), .rst_b_i(rst_b),
        .level_i(lvl), .slow_i(slow), .pins_o(pins));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ==========
    // Tasks
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic fail(input string m);
        error_cnt++;
        $display("ERROR %0t %s", $time, m);
    endtask : fail

    task automatic cmp_rd(input logic [31:0] got, input logic [31:0] e);
        checked++;
        if (got !== e) fail($sformatf("read %h exp %h", got, e));
    endtask : cmp_rd

    task automatic cmp_out(input logic [15:0] got, input logic [15:0] e);
        checked++;
        if (got !== e) fail($sformatf("port %h exp %h", got, e));
    endtask : cmp_out

    // Upper write bits are random: the block must ignore them
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [7:0] d);
        @(posedge clk);
        seed = lfsr(seed);
        adr   <= a;
        wdat  <= {seed[31:8], d};
        rd_en <= !w;
        wr_en <= w;
        do @(posedge clk); while (wreq !== 1'b0);
        rd_en <= 1'b0;
        wr_en <= 1'b0;
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
        #1;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        q.push_back({24'h0, e});
        bus(1'b0, a, 8'h00);
    endtask : rd

    // Pins settle, pass the synchroniser and reach the request
    task automatic drv(input logic [3:0] v);
        seed = lfsr(seed);
        @(posedge clk);
        lvl  <= v;
        slow <= seed[0];
        while (pins !== v) @(posedge clk);
        repeat (8) @(posedge clk);
        #1;
    endtask : drv

    task automatic test_done;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    always @(posedge clk) begin
        if (rd_en === 1'b1 && wreq === 1'b0) begin
            if (q.size() == 0) fail("read without note");
            else cmp_rd(rdat, q.pop_front());
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail("timeout");
            test_done();
        end
    end

    // ==========
    // Sequence
    initial begin
        {rst_b, rd_en, wr_en, boot, app_lk, done, ack, slow} = 8'h00;
        {adr, wdat, ackp} = '0;
        be = 4'h1;
        gie = 1'b1;
        boot_lk = 1'b0;
        lvl = 4'hf;
        seed = 32'hf4582f4b;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        rd(eirq_pkg::ADDR_SENSE, eirq_pkg::SENSE_RESET);
        wr(eirq_pkg::ADDR_ENABLE, 8'hf0);
        rd(eirq_pkg::ADDR_ENABLE, 8'h00);
        rd(eirq_pkg::ADDR_FLAG, 8'h00);
        wr(4'h2, 8'hff);
        rd(4'h2, 8'h00);
        // A write with lane 0 off must leave the register alone
        @(posedge clk);
        be <= 4'he;
        wr(eirq_pkg::ADDR_ENABLE, 8'h0f);
        @(posedge clk);
        be <= 4'h1;
        rd(eirq_pkg::ADDR_ENABLE, 8'h00);
        $display("test regs done");
        for (int p = 0; p < 4; p++) begin
            logic [1:0] m;
            logic [3:0] b;
            m = 2'(p);
            b = 4'h1 << p;
            wr(eirq_pkg::ADDR_ENABLE, 8'h00);
            drv(m == eirq_pkg::SENSE_RISE ? ~b : 4'hf);
            wr(eirq_pkg::ADDR_SENSE, {6'h0, m} << (2 * p));
            rd(eirq_pkg::ADDR_SENSE, {6'h0, m} << (2 * p));
            wr(eirq_pkg::ADDR_FLAG, {4'h0, b});
            wr(eirq_pkg::ADDR_ENABLE, {4'h0, b});
            cmp_out({15'h0, req}, 16'h0);
            drv(lvl ^ b);
            cmp_out({15'h0, req}, 16'h1);
            cmp_out({14'h0, rpin}, 16'(p));
            cmp_out(vec, eirq_pkg::APP_VECTOR_BASE + 16'(2 * p));
            if (m == eirq_pkg::SENSE_LOW) begin
                rd(eirq_pkg::ADDR_FLAG, 8'h00);
                cmp_out({15'h0, req}, 16'h1);
                drv(4'hf);
                cmp_out({15'h0, req}, 16'h0);
            end else begin
                rd(eirq_pkg::ADDR_FLAG, {4'h0, b});
                @(posedge clk);
                ack  <= 1'b1;
                ackp <= 2'(p);
                @(posedge clk);
                ack <= 1'b0;
                repeat (2) @(posedge clk);
                #1;
                cmp_out({15'h0, req}, 16'h0);
                rd(eirq_pkg::ADDR_FLAG, 8'h00);
            end
            $display("test pin %0d done", p);
        end
        wr(eirq_pkg::ADDR_ENABLE, 8'h00);
        @(posedge clk);
        gie <= 1'b0;
        wr(eirq_pkg::ADDR_SENSE, 8'h20);
        wr(eirq_pkg::ADDR_FLAG, 8'h04);
        wr(eirq_pkg::ADDR_ENABLE, 8'h04);
        drv(4'hb);
        cmp_out({15'h0, req}, 16'h0);
        rd(eirq_pkg::ADDR_FLAG, 8'h04);
        wr(eirq_pkg::ADDR_FLAG, 8'h04);
        rd(eirq_pkg::ADDR_FLAG, 8'h00);
        drv(4'hf);
        @(posedge clk);
        gie <= 1'b1;
        $display("test gate done");
        wr(eirq_pkg::ADDR_MCU_CTRL, 8'h01);
        cmp_out({15'h0, blk}, 16'h1);
        wr(eirq_pkg::ADDR_MCU_CTRL, 8'h02);
        cmp_out({15'h0, sel}, 16'h1);
        cmp_out({15'h0, blk}, 16'h1);
        @(posedge clk);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        cmp_out({15'h0, blk}, 16'h0);
        rd(eirq_pkg::ADDR_MCU_CTRL, 8'h02);
        drv(4'hb);
        cmp_out(vec, eirq_pkg::BOOT_RESET_ADDR + 16'h0008);
        wr(eirq_pkg::ADDR_MCU_CTRL, 8'h01);
        repeat (6) @(posedge clk);
        #1;
        cmp_out({15'h0, blk}, 16'h0);
        wr(eirq_pkg::ADDR_MCU_CTRL, 8'h00);
        rd(eirq_pkg::ADDR_MCU_CTRL, 8'h02);
        app_lk <= 1'b1;
        #1;
        cmp_out({15'h0, blk}, 16'h1);
        @(posedge clk);
        boot <= 1'b1;
        #1;
        cmp_out({15'h0, blk}, 16'h0);
        wr(eirq_pkg::ADDR_MCU_CTRL, 8'h01);
        wr(eirq_pkg::ADDR_MCU_CTRL, 8'h00);
        cmp_out({15'h0, sel}, 16'h0);
        @(posedge clk);
        done <= 1'b1;
        @(posedge clk);
        done    <= 1'b0;
        boot_lk <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        cmp_out({15'h0, blk}, 16'h1);
        cmp_out(vec, eirq_pkg::APP_VECTOR_BASE + 16'h0004);
        @(posedge clk);
        boot <= 1'b0;
        #1;
        cmp_out({15'h0, blk}, 16'h0);
        $display("test select done");
        test_done();
    end
endmodule : tb
`default_nettype wire
